// ---- dv/acr_host_model.sv ----
/*
 * Host side model: issues single-cycle register strobes in the way the
 * two-wire front end hands them to the register bank.
 * Assumes the bench calls its tasks from one process only.
 */
`timescale 1ns/1ps
module acr_host_model (
    // Clock
    input  wire logic             sys_clk,
    // Register access
    output acr_pkg::acr_reg_req_t reg_req,
    input  wire logic [7:0]       reg_rdata,
    input  wire logic             reg_rvalid
);
    initial reg_req = '0;

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        reg_req.wr    = 1'b1;
        reg_req.addr  = addr;
        reg_req.wdata = data;
        @(negedge sys_clk);
        reg_req = '0;
    endtask

    // The reserved upper field is always put back as written at reset.
    task automatic wr_hpf(input logic [2:0] code);
        wr(acr_pkg::OFS_HPF, {5'b0_1000, code});
    endtask

    // Read data is taken in the one cycle that rvalid stands.
    task automatic rd(input logic [7:0] addr, output logic [7:0] data,
                      output logic valid);
        @(negedge sys_clk);
        reg_req.rd   = 1'b1;
        reg_req.addr = addr;
        @(negedge sys_clk);
        data  = reg_rdata;
        valid = reg_rvalid;
        reg_req = '0;
    endtask
endmodule // acr_host_model

// ---- dv/testbench.sv ----
/*
 * Self-checking bench for the clip, current-limit and high-pass bank.
 * Assumes the host model above; detectors settle within ten cycles.
 */
`timescale 1ns/1ps
module testbench;
    logic                  sys_clk;
    logic                  srst;
    acr_pkg::acr_reg_req_t reg_req;
    logic [7:0]            reg_rdata;
    logic                  reg_rvalid;
    logic [3:0]            clip_detect_raw;
    logic [3:0]            current_cap_event;
    logic                  clip_detect_enable;
    logic                  overcurrent_pin_mask;
    logic [2:0]            sw_freq_sel;
    logic                  standby;
    logic [1:0]            parallel_bridge_req;
    logic [7:0]            chan_state;
    logic [1:0]            parallel_bridge_mode;
    logic [1:0]            bridge_pair_fault;
    logic [3:0]            diag_req;
    logic [51:0]           line_imp_ohms;
    logic [3:0]            diag_run;
    logic [3:0]            line_mode;
    logic [3:0]            line_amp_connected;
    logic                  warn_pin;
    logic [2:0]            highpass_cutoff_select;
    logic [5:0]            sw_ratio;
    int                    errors;
    int                    compares;

    acr_host_model u_host (.sys_clk(sys_clk), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    acr_regs u_dut (.sys_clk(sys_clk), .srst(srst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .clip_detect_raw(clip_detect_raw),
        .current_cap_event(current_cap_event),
        .clip_detect_enable(clip_detect_enable),
        .overcurrent_pin_mask(overcurrent_pin_mask),
        .sw_freq_sel(sw_freq_sel), .standby(standby),
        .parallel_bridge_req(parallel_bridge_req),
        .chan_state(chan_state),
        .parallel_bridge_mode(parallel_bridge_mode),
        .bridge_pair_fault(bridge_pair_fault), .diag_req(diag_req),
        .line_imp_ohms(line_imp_ohms), .diag_run(diag_run),
        .line_mode(line_mode), .line_amp_connected(line_amp_connected),
        .warn_pin(warn_pin),
        .highpass_cutoff_select(highpass_cutoff_select),
        .sw_ratio(sw_ratio));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic results();
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        u_host.rd(addr, d, v);
        chk("reg_rvalid", 8'h01, {7'h00, v});
        chk("reg_rdata", exp, d);
    endtask

    task automatic t_reset();
        rdchk(acr_pkg::OFS_CLIP, acr_pkg::RST_CLIP);
        rdchk(acr_pkg::OFS_ILIM, acr_pkg::RST_ILIM);
        rdchk(acr_pkg::OFS_HPF, acr_pkg::RST_HPF);
        rdchk(8'h10, acr_pkg::RD_UNMAPPED);
        chk("sw_ratio", {2'b00, acr_pkg::RATIO_44}, {2'b00, sw_ratio});
    endtask

    task automatic t_clip();
        clip_detect_raw = 4'b0101;
        settle(10);
        rdchk(acr_pkg::OFS_CLIP, 8'h05);
        u_host.wr(acr_pkg::OFS_CLIP, 8'hFF);
        rdchk(acr_pkg::OFS_CLIP, 8'h05);
        clip_detect_enable = 1'b0;
        settle(10);
        rdchk(acr_pkg::OFS_CLIP, 8'h00);
        clip_detect_enable = 1'b1;
        clip_detect_raw = 4'b0000;
    endtask

    task automatic t_ilim();
        current_cap_event = 4'b1010;
        settle(10);
        rdchk(acr_pkg::OFS_ILIM, 8'h0A);
        chk("warn_pin", 8'h01, {7'h00, warn_pin});
        overcurrent_pin_mask = 1'b1;
        settle(3);
        chk("warn_pin", 8'h00, {7'h00, warn_pin});
        current_cap_event = 4'b0000;
        settle(10);
        rdchk(acr_pkg::OFS_ILIM, 8'h00);
    endtask

    task automatic t_hpf();
        for (int c = 0; c < 8; c++) begin
            u_host.wr_hpf(3'(c));
            settle(1);
            chk("cutoff", 8'(c), {5'h00, highpass_cutoff_select});
            rdchk(acr_pkg::OFS_HPF, {5'b0_1000, 3'(c)});
        end
    endtask

    task automatic t_sw();
        logic [7:0] exp [6] = '{8'h26, 8'h2C, 8'h30, 8'h08, 8'h0A, 8'h2C};
        for (int i = 0; i < 6; i++) begin
            sw_freq_sel = 3'(i);
            settle(3);
            chk("sw_ratio", exp[i], {2'b00, sw_ratio});
        end
    endtask

    task automatic t_bridge();
        parallel_bridge_req = 2'b01;
        settle(3);
        chk("pb_mode", 8'h00, {6'h00, parallel_bridge_mode});
        standby = 1'b1;
        settle(3);
        chk("pb_mode", 8'h01, {6'h00, parallel_bridge_mode});
        standby = 1'b0;
        parallel_bridge_req = 2'b00;
        settle(3);
        chk("pb_mode", 8'h01, {6'h00, parallel_bridge_mode});
        chan_state = 8'h01;
        settle(3);
        chk("bridge_fault", 8'h01, {6'h00, bridge_pair_fault});
        chan_state = 8'h00;
        settle(3);
        chk("bridge_fault", 8'h00, {6'h00, bridge_pair_fault});
        diag_req = 4'b0011;
        settle(1);
        chk("diag_run", 8'h03, {4'h0, diag_run});
    endtask

    task automatic t_line();
        u_host.wr(acr_pkg::OFS_LINE_CFG, 8'h0F);
        settle(2);
        chk("line_mode", 8'h0F, {4'h0, line_mode});
        rdchk(acr_pkg::OFS_LINE_CFG, 8'h0F);
        line_imp_ohms = {13'h125D, 13'h125C, 13'h0257, 13'h0258};
        settle(3);
        chk("line_conn", 8'h05, {4'h0, line_amp_connected});
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        results();
    end

    initial begin
        errors = 0;
        compares = 0;
        srst = 1'b1;
        clip_detect_raw = 4'b0000;
        current_cap_event = 4'b0000;
        clip_detect_enable = 1'b1;
        overcurrent_pin_mask = 1'b0;
        sw_freq_sel = 3'h1;
        standby = 1'b0;
        parallel_bridge_req = 2'b00;
        chan_state = 8'h00;
        diag_req = 4'b0000;
        line_imp_ohms = '0;
        settle(20);
        srst = 1'b0;
        t_reset();
        t_clip();
        t_ilim();
        t_hpf();
        t_sw();
        t_bridge();
        t_line();
        results();
    end
endmodule // testbench

// ---- include/acr_pkg.sv ----
/*
 * Shared constants and types for the amplifier clip, current-limit and
 * high-pass status/control register bank.
 * Assumes a two-wire slave front end outside this block that turns bus
 * transactions into single-cycle register read and write strobes.
 */
// Contract
// - Register 0x24: read-only clip flag per channel, channel one in bit 0.
// - Current-limit register: read-only warning flag per channel, 1 on hit.
// - Current-limit register at 0x25 resets to zero; upper nibble reads 0.
// - Three-bit corner field selects high-pass cutoff, 3.7 Hz to 463 Hz.
// - Filter register 0x26 resets to 0x40; host writes reserved 01000 back.
// - Switching frequency selectable as 38, 44 or 48 times sample rate.
// - Paralleled pair raises a fault when its two state entries differ.
// - Parallel-bridge requests take effect only in standby.
// - Load diagnostics stay available for parallel-bridge channels.
// - Register 0x00 places each channel in line-driver mode.
// - Line check reports amplifier connected from 600 ohm to 4.7 kohm.
// - Mask bit 0 shows current-limit warnings on the warning pin, 1 hides.
// - Clip-detect enable resets to 1; when 0 no clip flags are produced.
package acr_pkg;

    localparam int         NUM_CHAN        = 4;
    localparam int         ADDR_W          = 8;
    localparam int         DATA_W          = 8;
    localparam int         IMP_W           = 13;
    localparam int         STATE_W         = 2;

    // Register offsets.
    localparam logic [7:0] OFS_LINE_CFG    = 8'h00;
    localparam logic [7:0] OFS_CLIP        = 8'h24;
    localparam logic [7:0] OFS_ILIM        = 8'h25;
    localparam logic [7:0] OFS_HPF         = 8'h26;

    // Reset values.
    localparam logic [7:0] RST_CLIP        = 8'h00;
    localparam logic [7:0] RST_ILIM        = 8'h00;
    localparam logic [7:0] RST_HPF         = 8'h40;
    localparam logic [7:0] RST_LINE_CFG    = 8'h00;
    localparam logic [7:0] RD_UNMAPPED     = 8'h00;
    localparam logic [3:0] RESV_NIBBLE     = 4'h0;

    // Field positions of the high-pass register.
    localparam int         HPF_LSB         = 0;
    localparam int         HPF_MSB         = 2;

    // Line-load window in ohms.
    localparam logic [12:0] LINE_IMP_MIN   = 13'h0258;
    localparam logic [12:0] LINE_IMP_MAX   = 13'h125C;

    // Switching ratio codes and the ratios they give.
    typedef enum logic [2:0] {
        SW_38FS = 3'b000,
        SW_44FS = 3'b001,
        SW_48FS = 3'b010,
        SW_8FS  = 3'b011,
        SW_10FS = 3'b100
    } acr_sw_sel_t;

    localparam logic [5:0] RATIO_38        = 6'h26;
    localparam logic [5:0] RATIO_44        = 6'h2C;
    localparam logic [5:0] RATIO_48        = 6'h30;
    localparam logic [5:0] RATIO_8         = 6'h08;
    localparam logic [5:0] RATIO_10        = 6'h0A;

    // One register access from the two-wire front end.
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } acr_reg_req_t;

endpackage

// ---- logic/acr_regs.sv ----
/*
 * Clip, current-limit and high-pass register bank with the related
 * switching-ratio, parallel-bridge and line-driver control logic.
 * Assumes the per-channel analog detectors arrive asynchronously and that
 * the two-wire front end issues at most one access per cycle.
 */
`timescale 1ns/1ps
module acr_regs #(
    parameter int NUM_CHAN = acr_pkg::NUM_CHAN
) (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     srst,
    // Register access
    input  wire acr_pkg::acr_reg_req_t    reg_req,
    output logic [acr_pkg::DATA_W-1:0]    reg_rdata,
    output logic                          reg_rvalid,
    // Analog detectors, asynchronous
    input  wire logic [NUM_CHAN-1:0]      clip_detect_raw,
    input  wire logic [NUM_CHAN-1:0]      current_cap_event,
    // Control bits held elsewhere
    input  wire logic                     clip_detect_enable,
    input  wire logic                     overcurrent_pin_mask,
    input  wire logic [2:0]               sw_freq_sel,
    // Parallel bridge
    input  wire logic                     standby,
    input  wire logic [1:0]               parallel_bridge_req,
    input  wire logic [NUM_CHAN*acr_pkg::STATE_W-1:0] chan_state,
    output logic [1:0]                    parallel_bridge_mode,
    output logic [1:0]                    bridge_pair_fault,
    // Load and line diagnostics
    input  wire logic [NUM_CHAN-1:0]      diag_req,
    input  wire logic [NUM_CHAN*acr_pkg::IMP_W-1:0] line_imp_ohms,
    output logic [NUM_CHAN-1:0]           diag_run,
    output logic [NUM_CHAN-1:0]           line_mode,
    output logic [NUM_CHAN-1:0]           line_amp_connected,
    // Status and control outputs
    output logic                          warn_pin,
    output logic [2:0]                    highpass_cutoff_select,
    output logic [5:0]                    sw_ratio
);

    logic [NUM_CHAN-1:0] clip_s1_r, clip_s2_r, clip_s3_r, clip_flt_r;
    logic [NUM_CHAN-1:0] ilim_s1_r, ilim_s2_r, ilim_s3_r, ilim_flt_r;
    logic [NUM_CHAN-1:0] clip_flags_r, ilim_flags_r;
    logic [7:0]          hpf_ctrl_r;
    logic [7:0]          line_cfg_r;
    logic [1:0]          bridge_mode_r;
    logic [1:0]          bridge_fault_r;
    logic                warn_r;
    logic [5:0]          sw_ratio_r;
    logic [NUM_CHAN-1:0] line_conn_r;
    logic [7:0]          rdata_r;
    logic                rvalid_r;
    logic [7:0]          rdata_nxt;

    // Three-stage synchronisers; a change counts once stages two and three
    // agree, so a single metastable sample never reaches the flags.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clip_s1_r <= '0;
            clip_s2_r <= '0;
            clip_s3_r <= '0;
            ilim_s1_r <= '0;
            ilim_s2_r <= '0;
            ilim_s3_r <= '0;
        end else begin
            clip_s1_r <= clip_detect_raw;
            clip_s2_r <= clip_s1_r;
            clip_s3_r <= clip_s2_r;
            ilim_s1_r <= current_cap_event;
            ilim_s2_r <= ilim_s1_r;
            ilim_s3_r <= ilim_s2_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clip_flt_r <= '0;
            ilim_flt_r <= '0;
        end else begin
            clip_flt_r <= (clip_s2_r & clip_s3_r)
                        | (clip_flt_r & (clip_s2_r ^ clip_s3_r));
            ilim_flt_r <= (ilim_s2_r & ilim_s3_r)
                        | (ilim_flt_r & (ilim_s2_r ^ ilim_s3_r));
        end
    end

    // Status flags follow the live condition; they are not sticky.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clip_flags_r <= acr_pkg::RST_CLIP[NUM_CHAN-1:0];
            ilim_flags_r <= acr_pkg::RST_ILIM[NUM_CHAN-1:0];
        end else begin
            clip_flags_r <= clip_detect_enable ? clip_flt_r : '0;
            ilim_flags_r <= ilim_flt_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            warn_r <= 1'b0;
        end else begin
            warn_r <= (|ilim_flags_r) & ~overcurrent_pin_mask;
        end
    end

    // Writable registers; reserved bits of the filter register are stored
    // as written so the host's write-back of 01000 reads back intact.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hpf_ctrl_r <= acr_pkg::RST_HPF;
            line_cfg_r <= acr_pkg::RST_LINE_CFG;
        end else if (reg_req.wr) begin
            if (reg_req.addr == acr_pkg::OFS_HPF) begin
                hpf_ctrl_r <= reg_req.wdata;
            end
            if (reg_req.addr == acr_pkg::OFS_LINE_CFG) begin
                line_cfg_r <= reg_req.wdata;
            end
        end
    end

    // Reads are captured in one edge from registered flags, so every bit
    // of a returned byte comes from the same cycle.
    always_comb begin
        rdata_nxt = acr_pkg::RD_UNMAPPED;
        unique case (reg_req.addr)
            acr_pkg::OFS_CLIP:
                rdata_nxt = {acr_pkg::RESV_NIBBLE, clip_flags_r};
            acr_pkg::OFS_ILIM:
                rdata_nxt = {acr_pkg::RESV_NIBBLE, ilim_flags_r};
            acr_pkg::OFS_HPF:
                rdata_nxt = hpf_ctrl_r;
            acr_pkg::OFS_LINE_CFG:
                rdata_nxt = line_cfg_r;
            default:
                rdata_nxt = acr_pkg::RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_req.rd;
            if (reg_req.rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // Illegal selector codes fall back to the 44x ratio.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sw_ratio_r <= acr_pkg::RATIO_44;
        end else begin
            unique case (sw_freq_sel)
                acr_pkg::SW_38FS: sw_ratio_r <= acr_pkg::RATIO_38;
                acr_pkg::SW_44FS: sw_ratio_r <= acr_pkg::RATIO_44;
                acr_pkg::SW_48FS: sw_ratio_r <= acr_pkg::RATIO_48;
                acr_pkg::SW_8FS:  sw_ratio_r <= acr_pkg::RATIO_8;
                acr_pkg::SW_10FS: sw_ratio_r <= acr_pkg::RATIO_10;
                default:          sw_ratio_r <= acr_pkg::RATIO_44;
            endcase
        end
    end

    // Pair 0 is channels one and two, pair 1 channels three and four.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bridge_mode_r <= '0;
        end else if (standby) begin
            bridge_mode_r <= parallel_bridge_req;
        end
    end

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pair
            localparam int LO = 2 * p * acr_pkg::STATE_W;
            localparam int HI = LO + acr_pkg::STATE_W;
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    bridge_fault_r[p] <= 1'b0;
                end else begin
                    bridge_fault_r[p] <= bridge_mode_r[p] &&
                        (chan_state[LO +: acr_pkg::STATE_W] !=
                         chan_state[HI +: acr_pkg::STATE_W]);
                end
            end
        end
    endgenerate

    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++) begin : g_chan
            logic [acr_pkg::IMP_W-1:0] imp;
            assign imp = line_imp_ohms[c*acr_pkg::IMP_W +: acr_pkg::IMP_W];
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    line_conn_r[c] <= 1'b0;
                end else begin
                    line_conn_r[c] <= line_cfg_r[c]
                        && imp >= acr_pkg::LINE_IMP_MIN
                        && imp <= acr_pkg::LINE_IMP_MAX;
                end
            end
        end
    endgenerate

    assign reg_rdata              = rdata_r;
    assign reg_rvalid             = rvalid_r;
    assign warn_pin               = warn_r;
    assign highpass_cutoff_select =
        hpf_ctrl_r[acr_pkg::HPF_MSB:acr_pkg::HPF_LSB];
    assign sw_ratio               = sw_ratio_r;
    assign parallel_bridge_mode   = bridge_mode_r;
    assign bridge_pair_fault      = bridge_fault_r;
    assign line_mode              = line_cfg_r[NUM_CHAN-1:0];
    assign line_amp_connected     = line_conn_r;
    // Diagnostics are never gated by the bridge pairing.
    assign diag_run               = diag_req;

    sequence s_clip_settled;
        clip_detect_enable && (clip_s2_r == clip_s3_r);
    endsequence

    sequence s_clip_held;
        s_clip_settled ##1 clip_detect_enable;
    endsequence

    chk_clip_follow: assert property (@(posedge sys_clk)
        disable iff (srst)
        s_clip_held |=> clip_flags_r == $past(clip_s3_r, 2))
        else $error("clip flags do not follow settled detector");

    chk_clip_enable_gate: assert property (@(posedge sys_clk)
        disable iff (srst)
        !clip_detect_enable |=> clip_flags_r == '0)
        else $error("clip flag set while detection disabled");

    chk_ilim_read_snap: assert property (@(posedge sys_clk)
        disable iff (srst)
        reg_req.rd && reg_req.addr == acr_pkg::OFS_ILIM
        |=> reg_rvalid && reg_rdata[3:0] == $past(ilim_flags_r))
        else $error("current-limit read lost its snapshot");

    chk_ilim_resv_zero: assert property (@(posedge sys_clk)
        disable iff (srst)
        reg_req.rd && reg_req.addr == acr_pkg::OFS_ILIM
        |=> reg_rdata[7:4] == acr_pkg::RESV_NIBBLE)
        else $error("reserved current-limit bits not zero");

    chk_hpf_write_back: assert property (@(posedge sys_clk)
        disable iff (srst)
        reg_req.wr && reg_req.addr == acr_pkg::OFS_HPF
        |=> hpf_ctrl_r == $past(reg_req.wdata)
            && highpass_cutoff_select == $past(reg_req.wdata[2:0]))
        else $error("filter register write not applied");

    chk_bridge_standby: assert property (@(posedge sys_clk)
        disable iff (srst)
        !standby |=> $stable(parallel_bridge_mode))
        else $error("bridge pairing changed outside standby");

    chk_bridge_mismatch: assert property (@(posedge sys_clk)
        disable iff (srst)
        bridge_mode_r[0] && chan_state[1:0] != chan_state[3:2]
        |=> bridge_pair_fault[0])
        else $error("bridge state mismatch not flagged");

    chk_warn_mask: assert property (@(posedge sys_clk)
        disable iff (srst)
        (|ilim_flags_r) && !overcurrent_pin_mask |=> warn_pin)
        else $error("warning pin not raised for current limit");

    chk_warn_masked: assert property (@(posedge sys_clk)
        disable iff (srst)
        overcurrent_pin_mask |=> !warn_pin)
        else $error("warning pin ignores the mask");

    chk_line_window: assert property (@(posedge sys_clk)
        disable iff (srst)
        line_cfg_r[0] && line_imp_ohms[12:0] >= acr_pkg::LINE_IMP_MIN
        && line_imp_ohms[12:0] <= acr_pkg::LINE_IMP_MAX
        |=> line_amp_connected[0])
        else $error("line amplifier in window not reported");

    chk_sw_ratio_44: assert property (@(posedge sys_clk)
        disable iff (srst)
        sw_freq_sel == acr_pkg::SW_44FS |=> sw_ratio == acr_pkg::RATIO_44)
        else $error("switching ratio 44 not selected");

endmodule // acr_regs
